// [hw/tpt_pkg.sv]
package tpt_pkg;

  // ----------------------------------------------------------------
  // Panel timing, dot clocks per line and lines per frame
  // ----------------------------------------------------------------
  // Dot clock rate that the panel expects, in MHz.
  localparam real DOT_CLK_MHZ = 33.3;
  // Counter width covers the longest axis total.
  localparam int unsigned CNT_W = 11;
  localparam int unsigned H_SYNC = 8;
  localparam int unsigned H_BACK = 38;
  localparam int unsigned H_ACT = 800;
  localparam int unsigned H_FRONT = 210;
  localparam int unsigned H_TOTAL = H_SYNC + H_BACK + H_ACT + H_FRONT;
  localparam int unsigned V_SYNC = 1;
  localparam int unsigned V_BACK = 22;
  localparam int unsigned V_ACT = 480;
  localparam int unsigned V_FRONT = 22;
  localparam int unsigned V_TOTAL = V_SYNC + V_BACK + V_ACT + V_FRONT;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FILL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FRAMES = 8'h0C;
  // Control field positions: scan enable and pixel source select.
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  // Scanning starts out of reset with the fill colour as source.
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] FILL_RST = 16'h0000;

endpackage

// [hw/tpt_sync2.sv]
`timescale 1ns/1ps
// Two flip-flop synchroniser for levels and gray-coded words.
module tpt_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Destination clock and its synchronous reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // First stage is read only by the second stage.
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Both stages register on every rising edge.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// [hw/tpt_axis.sv]
`timescale 1ns/1ps
// One scan axis: sync, back porch, active, front porch, then wrap.
module tpt_axis
  import tpt_pkg::*;
#(
  parameter int unsigned SYNC = 1,
  parameter int unsigned BACK = 1,
  parameter int unsigned ACT = 1,
  parameter int unsigned FRONT = 1
) (
  // Clock, reset and advance strobe.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  // Position and phase flags.
  output logic [CNT_W-1:0] cnt_o,
  output logic sync_o,
  output logic active_o,
  output logic last_o
);

  // Phase boundaries at counter width.
  localparam logic [CNT_W-1:0] ACT_LO = CNT_W'(SYNC + BACK);
  localparam logic [CNT_W-1:0] ACT_HI = CNT_W'(SYNC + BACK + ACT);
  localparam logic [CNT_W-1:0] SYNC_END = CNT_W'(SYNC);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(SYNC + BACK + ACT + FRONT - 1);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // Phase order is fixed by the counter itself, so it cannot drift.
  assign last_o = (cnt_q == LAST);
  assign sync_o = (cnt_q < SYNC_END);
  assign active_o = (cnt_q >= ACT_LO) && (cnt_q < ACT_HI);
  assign cnt_o = cnt_q;

  // Next position: hold, step, or wrap to the sync phase.
  always_comb
  begin
    cnt_d = cnt_q;
    if (step_i)
    begin
      cnt_d = last_o ? '0 : cnt_q + CNT_W'(1);
    end
  end

  // Position register.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// [hw/tpt_timing.sv]
`timescale 1ns/1ps
// Function
// - Dot clock 33.3 MHz, outputs on falling edge.
// - Exactly 800 active pixels per line.
// - Horizontal sync low for 8 dot clocks.
// - 38 dot clock back porch after sync.
// - 210 dot clock front porch after pixels.
// - Exactly 480 active lines per frame.
// - Vertical sync low for one line.
// - 22 blank lines after vertical sync.
// - 22 blank lines before next vertical sync.
// - Sync mode plus high data enable output.
// - 16-bit RGB bus, 16 bits per pixel.
module tpt_timing
  import tpt_pkg::*;
(
  // System clock and reset.
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Panel link.
  input wire logic DOT_CLK_I,
  output logic DOT_CLK_O,
  output logic HSYNC_N_O,
  output logic VSYNC_N_O,
  output logic DE_O,
  output logic [15:0] RGB_O
);

  // ----------------------------------------------------------------
  // System side register file
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q, ctrl_d;     // Enable and pixel source.
  logic [15:0] fill_q, fill_d;    // Fill colour in RGB565.
  logic [17:0] hold_q, hold_d;    // Word held steady for the crossing.
  logic req_q, req_d;             // Request toggle towards the dot side.
  logic dirty_q, dirty_d;         // Settings written but not yet sent.
  logic [31:0] rdata_q, rdata_d;  // Read answer.
  logic ack_s;                    // Synchronised acknowledge toggle.
  logic [1:0] stat_s;             // Running and blanking, synchronised.
  logic [15:0] frames_gs;         // Gray frame count, synchronised.
  logic [15:0] frames_bin;        // Binary frame count.
  logic busy;                     // A transfer is still outstanding.
  logic launch;                   // Send the shadow settings now.
  logic wr_cfg;                   // A write touched the settings.

  assign busy = req_q ^ ack_s;
  assign launch = dirty_q && !busy;
  assign wr_cfg = WR_I && ((ADDR_I == OFS_CTRL) || (ADDR_I == OFS_FILL));

  // Gray to binary conversion of the frame count.
  always_comb
  begin
    frames_bin = '0;
    frames_bin[15] = frames_gs[15];
    for (int i = 14; i >= 0; i--)
    begin
      frames_bin[i] = frames_bin[i+1] ^ frames_gs[i];
    end
  end

  // Register writes, crossing launch and read answers.
  always_comb
  begin
    ctrl_d = ctrl_q;
    fill_d = fill_q;
    hold_d = hold_q;
    req_d = req_q;
    rdata_d = '0;
    // A write in the launch cycle keeps the dirty flag set.
    dirty_d = (dirty_q && !launch) || wr_cfg;
    if (WR_I && (ADDR_I == OFS_CTRL))
    begin
      ctrl_d = WDATA_I[1:0];
    end
    if (WR_I && (ADDR_I == OFS_FILL))
    begin
      fill_d = WDATA_I[15:0];
    end
    // The held word changes only while no transfer is open.
    if (launch)
    begin
      hold_d = {ctrl_q, fill_q};
      req_d = !req_q;
    end
    if (RD_I)
    begin
      case (ADDR_I)
        OFS_CTRL: rdata_d = {30'h00000000, ctrl_q};
        OFS_FILL: rdata_d = {16'h0000, fill_q};
        OFS_STATUS: rdata_d = {29'h00000000, dirty_q || busy, stat_s};
        OFS_FRAMES: rdata_d = {16'h0000, frames_bin};
        // Unmapped addresses read as zero.
        default: rdata_d = '0;
      endcase
    end
  end

  // System side state registers.
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      ctrl_q <= CTRL_RST;
      fill_q <= FILL_RST;
      hold_q <= {CTRL_RST, FILL_RST};
      req_q <= 1'b0;
      dirty_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      fill_q <= fill_d;
      hold_q <= hold_d;
      req_q <= req_d;
      dirty_q <= dirty_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA_O = rdata_q;

  // ----------------------------------------------------------------
  // Crossings between the two clocks
  // ----------------------------------------------------------------
  logic dot_rst_n;   // System reset seen in the dot domain.
  logic req_s;       // Request toggle seen in the dot domain.
  logic ack_q, ack_d;
  logic [1:0] stat_q;
  logic [15:0] frames_g_q;

  // Reset release is delayed two dot clocks; the dot clock must run.
  tpt_sync2 #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk_i(DOT_CLK_I), .rst_n_i(1'b1), .d_i(NRST_I), .q_o(dot_rst_n));
  tpt_sync2 #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk_i(DOT_CLK_I), .rst_n_i(dot_rst_n), .d_i(req_q), .q_o(req_s));
  tpt_sync2 #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk_i(CLK_I), .rst_n_i(NRST_I), .d_i(ack_q), .q_o(ack_s));
  tpt_sync2 #(.W(2), .RST_VAL(2'h0)) u_stat_sync (
    .clk_i(CLK_I), .rst_n_i(NRST_I), .d_i(stat_q), .q_o(stat_s));
  // Gray coding makes the multi-bit count safe to sample.
  tpt_sync2 #(.W(16), .RST_VAL(16'h0000)) u_frm_sync (
    .clk_i(CLK_I), .rst_n_i(NRST_I), .d_i(frames_g_q), .q_o(frames_gs));

  // ----------------------------------------------------------------
  // Dot clock scan engine
  // ----------------------------------------------------------------
  logic [17:0] cap_q, cap_d;    // Last word taken from the handshake.
  logic [17:0] live_q, live_d;  // Settings in force for this frame.
  logic [15:0] frames_q, frames_d;
  logic run, run_n, frame_end;
  logic [CNT_W-1:0] h_cnt, v_cnt, px, py;
  logic h_sync, h_act, h_last, v_sync, v_act, v_last;
  logic hs_q, hs_d, vs_q, vs_d, de_q, de_d;
  logic [15:0] rgb_q, rgb_d;

  assign run = live_q[16+CTRL_EN_BIT];
  assign run_n = dot_rst_n && run;
  assign frame_end = h_last && v_last;
  assign px = h_cnt - CNT_W'(H_SYNC + H_BACK);
  assign py = v_cnt - CNT_W'(V_SYNC + V_BACK);

  tpt_axis #(.SYNC(H_SYNC), .BACK(H_BACK), .ACT(H_ACT), .FRONT(H_FRONT)) u_h (
    .clk_i(DOT_CLK_I), .rst_n_i(run_n), .step_i(1'b1),
    .cnt_o(h_cnt), .sync_o(h_sync), .active_o(h_act), .last_o(h_last));
  tpt_axis #(.SYNC(V_SYNC), .BACK(V_BACK), .ACT(V_ACT), .FRONT(V_FRONT)) u_v (
    .clk_i(DOT_CLK_I), .rst_n_i(run_n), .step_i(h_last),
    .cnt_o(v_cnt), .sync_o(v_sync), .active_o(v_act), .last_o(v_last));

  // Handshake capture, frame-aligned settings and pixel generation.
  always_comb
  begin
    cap_d = cap_q;
    ack_d = ack_q;
    live_d = live_q;
    frames_d = frames_q;
    // The held word is stable while the toggles differ.
    if (req_s != ack_q)
    begin
      cap_d = hold_q;
      ack_d = req_s;
    end
    if (frame_end || !run)
    begin
      live_d = cap_q;
    end
    if (frame_end)
    begin
      frames_d = frames_q + 16'h0001;
    end
    hs_d = !(run && h_sync);
    vs_d = !(run && v_sync);
    de_d = run && h_act && v_act;
    rgb_d = 16'h0000;
    if (de_d)
    begin
      rgb_d = live_q[16+CTRL_MODE_BIT] ? {px[9:5], py[8:3], px[4:0] ^ py[4:0]} : live_q[15:0];
    end
  end

  // Dot domain registers on the rising edge.
  always_ff @(posedge DOT_CLK_I)
  begin
    if (!dot_rst_n)
    begin
      cap_q <= {CTRL_RST, FILL_RST};
      live_q <= {CTRL_RST, FILL_RST};
      ack_q <= 1'b0;
      frames_q <= '0;
      frames_g_q <= '0;
      stat_q <= '0;
      hs_q <= 1'b1;
      vs_q <= 1'b1;
      de_q <= 1'b0;
      rgb_q <= '0;
    end
    else
    begin
      cap_q <= cap_d;
      live_q <= live_d;
      ack_q <= ack_d;
      frames_q <= frames_d;
      frames_g_q <= frames_q ^ (frames_q >> 1);
      stat_q <= {!v_act, run};
      hs_q <= hs_d;
      vs_q <= vs_d;
      de_q <= de_d;
      rgb_q <= rgb_d;
    end
  end

  // ----------------------------------------------------------------
  // Falling edge launch towards the panel
  // ----------------------------------------------------------------
  // The clock is forwarded; the panel samples on its rising edge,
  // half a period after the data change, which centres the window.
  assign DOT_CLK_O = DOT_CLK_I;

  // Outputs change on the falling edge
  always_ff @(negedge DOT_CLK_I)
  begin
    if (!dot_rst_n)
    begin
      HSYNC_N_O <= 1'b1;
      VSYNC_N_O <= 1'b1;
      DE_O <= 1'b0;
      RGB_O <= '0;
    end
    else
    begin
      HSYNC_N_O <= hs_q;
      VSYNC_N_O <= vs_q;
      DE_O <= de_q;
      RGB_O <= rgb_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks on the panel outputs
  // ----------------------------------------------------------------
  logic hs_p_q, vs_p_q, de_p_q, warm_q;
  logic [CNT_W-1:0] de_run_q, gap_q, vline_q, lines_q, vl_q, last_de_q;
  logic hs_fall, vs_fall, de_rise;

  assign hs_fall = hs_p_q && !HSYNC_N_O;
  assign vs_fall = vs_p_q && !VSYNC_N_O;
  assign de_rise = !de_p_q && DE_O;

  // Helper counters that only the checks read.
  always_ff @(negedge DOT_CLK_I)
  begin
    if (!dot_rst_n)
    begin
      // Previous values start at the idle pin levels, so no false edge follows reset.
      {hs_p_q, vs_p_q, de_p_q, warm_q} <= 4'hC;
      {de_run_q, gap_q, vline_q, lines_q, vl_q, last_de_q} <= '0;
    end
    else
    begin
      {hs_p_q, vs_p_q, de_p_q} <= {HSYNC_N_O, VSYNC_N_O, DE_O};
      warm_q <= warm_q || vs_fall;
      de_run_q <= DE_O ? de_run_q + CNT_W'(1) : '0;
      gap_q <= hs_fall ? '0 : gap_q + CNT_W'(1);
      vline_q <= !VSYNC_N_O ? vline_q + CNT_W'(hs_fall) : '0;
      lines_q <= vs_fall ? '0 : lines_q + CNT_W'(de_rise);
      vl_q <= vs_fall ? '0 : vl_q + CNT_W'(hs_fall);
      last_de_q <= (de_p_q && !DE_O) ? vl_q : last_de_q;
    end
  end

  AST_HSYNC_WIDTH: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    $fell(HSYNC_N_O) |-> (!HSYNC_N_O)[*8] ##1 HSYNC_N_O) else $error("line sync width wrong");
  AST_H_BACK: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    $rose(DE_O) |-> $past(HSYNC_N_O, 38) && !$past(HSYNC_N_O, 39)) else $error("back porch wrong");
  AST_H_FRONT: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    $fell(DE_O) |-> ##210 $fell(HSYNC_N_O)) else $error("front porch wrong");
  AST_DE_WIDTH: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    $fell(DE_O) |-> de_run_q == CNT_W'(H_ACT)) else $error("active width wrong");
  AST_LINE_LEN: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    hs_fall && warm_q |-> gap_q == CNT_W'(H_TOTAL - 1)) else $error("line length wrong");
  AST_VSYNC_WIDTH: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    $rose(VSYNC_N_O) |-> vline_q == CNT_W'(1) && $fell(HSYNC_N_O)) else $error("frame sync width wrong");
  AST_V_LINES: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    vs_fall && warm_q |-> lines_q == CNT_W'(V_ACT)) else $error("active line count wrong");
  AST_V_BACK: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    de_rise && lines_q == '0 |-> vl_q == CNT_W'(V_SYNC + V_BACK)) else $error("vertical back porch wrong");
  AST_V_FRONT: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    vs_fall && warm_q |-> vl_q - last_de_q == CNT_W'(V_FRONT)) else $error("vertical front porch wrong");
  AST_DE_BLANK: assert property (@(negedge DOT_CLK_I) disable iff (!dot_rst_n)
    !DE_O |-> RGB_O == 16'h0000) else $error("data outside enable");

endmodule

// [bench/tpt_panel_model.sv]
`timescale 1ns/1ps
// --------------------------------
// Panel model
// --------------------------------
// Samples the link on rising dot edges, as the glass does, and measures each line.
module tpt_panel_model
#(
  parameter int NL = 25
)
(
  // Link from the timing block.
  input wire logic dot_clock_i,
  input wire logic hsync_n_i,
  input wire logic vsync_n_i,
  input wire logic de_i,
  input wire logic [15:0] rgb_i,
  // Measurement control.
  input wire logic arm_i,
  output logic done_o
);
  // Dot and line position since the first frame sync.
  int h = 0;
  int ln = 0;
  bit run = 0;
  // Results that the bench reads.
  int vsw = 0;
  int fde = -1;
  int zerr = 0;
  int eerr = 0;
  int hsw [NL];
  int dest [NL];
  int del [NL];
  int tot [NL];
  // Time of the last change on any sync, enable or pixel line of the link.
  realtime tchg = 0;
  logic phs = 1'b1;
  logic pvs = 1'b1;
  logic pde = 1'b0;

  // The run is over once the line after the last measured one has begun.
  assign done_o = run && (ln >= NL);

  // Note every change; a change close to the sampling edge would break panel setup.
  always @(hsync_n_i or vsync_n_i or de_i or rgb_i)
  begin
    tchg = $realtime;
  end

  // Count dots between sync falls and record every phase of the line.
  always @(posedge dot_clock_i)
  begin
    if (arm_i && !done_o)
    begin
      if (run && ($realtime - tchg) < 20.0)
        eerr++;
      if (!hsync_n_i && phs)
      begin
        if (run)
        begin
          tot[ln] = h + 1;
          ln++;
        end
        // Only the first frame sync starts the run.
        if (!vsync_n_i && pvs && !run)
          run = 1;
        h = 0;
      end
      else
        h++;
      if (run && ln < NL)
      begin
        if (!hsync_n_i)
          hsw[ln]++;
        if (!vsync_n_i)
          vsw++;
        if (de_i && !pde)
          dest[ln] = h;
        if (de_i)
          del[ln]++;
        if (de_i && fde < 0)
          fde = ln;
        if (!de_i && rgb_i !== 16'h0000)
          zerr++;
      end
    end
    phs = hsync_n_i;
    pvs = vsync_n_i;
    pde = de_i;
  end
endmodule

// [bench/tpt_timing_tb.sv]
`timescale 1ns/1ps
// --------------------------------
// Testbench
// --------------------------------
module tpt_timing_tb
  import tpt_pkg::*;
;
  // Lines measured: sync line, back porch and two active lines.
  localparam int NL = 25;
  // System side stimulus.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  // Link side.
  logic dot_clock = 1'b0;
  logic dot_clock_out;
  logic hs_n;
  logic vs_n;
  logic de;
  logic [15:0] rgb;
  logic done;
  logic arm = 1'b0;
  // Bookkeeping.
  int fails = 0;
  int comparisons = 0;
  int seed = 32'hB5B9E30C;
  logic [15:0] fill;
  logic [1:0] ctrl;

  tpt_timing DUT (.CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_stb),
    .RD_I(rd_stb), .RDATA_O(rdata), .DOT_CLK_I(dot_clock), .DOT_CLK_O(dot_clock_out), .HSYNC_N_O(hs_n),
    .VSYNC_N_O(vs_n), .DE_O(de), .RGB_O(rgb));

  tpt_panel_model #(.NL(NL)) u_panel (.dot_clock_i(dot_clock_out), .hsync_n_i(hs_n), .vsync_n_i(vs_n),
    .de_i(de), .rgb_i(rgb), .arm_i(arm), .done_o(done));

  // System clock, 8 ns period.
  initial
  begin
    forever #4 clk = ~clk;
  end

  // Dot clock, 80 ns period, offset by 13.7 ns so its edges fall between system clock edges.
  initial
  begin
    #13.7;
    forever #40 dot_clock = ~dot_clock;
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  // Compare, count, and report at once on a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s: got %0h, expected %0h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // One-cycle read strobe; data stand only in the following cycle.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e, what);
    @(posedge clk);
    #1 chk(rdata, 32'h00000000, "read data held too long");
  endtask

  // Enabled dots expected on a given line of the frame.
  function automatic int exp_de_len(input int i);
    return (i >= V_SYNC + V_BACK && i < V_SYNC + V_BACK + V_ACT) ? H_ACT : 0;
  endfunction

  // Print the counts and the verdict, then stop.
  task automatic end_sim();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------------------
  // Checks
  // --------------------------------
  // The fill change waits for the frame wrap, so the first frame shows the reset colour.
  always @(posedge dot_clock_out)
  begin
    if (u_panel.run && done !== 1'b1 && de === 1'b1)
    begin
      chk({16'h0000, rgb}, {16'h0000, FILL_RST}, "pixel colour");
    end
  end

  // A full frame would be far too long, so only its first 25 lines are measured.
  initial
  begin
    // Reset spans several dot periods, since the dot side sees it through two flops.
    repeat (40) @(posedge clk);
    rst_n <= 1'b1;
    arm <= 1'b1;
    reg_rd(OFS_CTRL, {30'h0, CTRL_RST}, "control reset value");
    reg_rd(OFS_FILL, {16'h0000, FILL_RST}, "fill reset value");
    reg_rd(8'h10, 32'h00000000, "unmapped read");
    fill = 16'($random(seed));
    reg_wr(OFS_FILL, {16'h0000, fill});
    // Dot side still in reset: nothing running yet, the fill update is pending.
    reg_rd(OFS_STATUS, 32'h00000004, "status before dot side runs");
    reg_wr(8'h10, $random(seed));
    reg_wr(OFS_STATUS, 32'hFFFFFFFF);
    reg_rd(OFS_FILL, {16'h0000, fill}, "fill read back");
    reg_rd(8'h10, 32'h00000000, "unmapped after write");
    for (int n = 0; n < 2000 && !u_panel.run; n++)
      @(posedge clk);
    repeat (40) @(posedge clk);
    // Running, in vertical blank, fill update already handed to the dot side.
    reg_rd(OFS_STATUS, 32'h00000003, "status in blank");
    for (int n = 0; n < 300000 && done !== 1'b1; n++)
      @(posedge clk);
    chk({31'h0, done}, 32'h00000001, "frame start not measured");
    for (int i = 0; i < NL; i++)
    begin
      chk(u_panel.hsw[i], H_SYNC, "line sync width");
      chk(u_panel.tot[i], H_TOTAL, "line length");
      chk(u_panel.del[i], exp_de_len(i), "enabled dots");
      if (exp_de_len(i) > 0)
      begin
        chk(u_panel.dest[i], H_SYNC + H_BACK, "back porch");
        chk(u_panel.tot[i] - u_panel.dest[i] - H_ACT, H_FRONT, "front porch");
      end
    end
    chk(u_panel.vsw, V_SYNC * H_TOTAL, "frame sync width");
    chk(u_panel.fde, V_SYNC + V_BACK, "first active line");
    chk(u_panel.zerr, 0, "pixels outside enable");
    chk(u_panel.eerr, 0, "change near sampling edge");
    // Active region, nothing pending: the handed-over fill only waits for the wrap.
    reg_rd(OFS_STATUS, 32'h00000001, "status in active lines");
    reg_rd(OFS_FRAMES, 32'h00000000, "frame count");
    // A control write reads back at once and stays pending until the dot side takes it.
    ctrl = 2'($random(seed));
    reg_wr(OFS_CTRL, {30'h0, ctrl});
    reg_rd(OFS_CTRL, {30'h0, ctrl}, "control read back");
    reg_rd(OFS_STATUS, 32'h00000005, "status with update pending");
    end_sim();
  end

  // Watchdog sized for 25 lines of dots plus margin.
  initial
  begin
    repeat (400000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
